// ---- hw/ras_sysregs.v ----
// error record system registers: deferred status, record count, select and windows
`timescale 1ns/1ps
`include "ras_defs.vh"
// Operation
// - deferred flag bit 31 set when a barrier defers a system error interrupt
// - both EL1 layouts report error kind 0b01 in bits 15:14
// - short layout: fault code bit 4 at 10, bits 3:0 low, bit 9 format indicator
// - long layout: bit 9 format indicator, six-bit code in 5:0, 11:10 zero
// - format indicator stores software's value and steers nothing
// - EL2 writes use layout: flag 31, kind 11:10, code 5:0, rest zero
// - EL2 flag held zero without synchronizable error sources
// - abort kind bit 12 reads zero in EL1 layouts
// - record count reads 0x0002 in low half, zero above
// - select bit 0 picks core record or cluster record for windows
// - select register keeps its value through warm reset
// - low address window reaches address bits 31:0
// - high address window reaches address bits 63:32
// - low control window reaches control bits 31:0
// - record 1 accesses go to the cluster record over the link
// - one count and one select register for both security states
// - high control window reaches control bits 62:32
// - low feature window reaches feature bits 31:0
module ras_sysregs #(
    parameter HAS_SYNC_SOURCES = 1
) (
    input wire mclk,
    input wire resetn,
    input wire cold_resetn,
    input wire clk_en,
    input wire reg_wr,
    input wire reg_rd,
    input wire [2:0] reg_sel,
    input wire [31:0] reg_wdata,
    input wire wr_at_el2,
    input wire long_format_enable,
    output reg [31:0] reg_rdata,
    output reg reg_rvalid,
    input wire error_sync_barrier,
    input wire [5:0] fault_status_code,
    output reg [63:0] core_addr_reg,
    output reg [63:0] core_ctrl_reg,
    input wire [31:0] core_feature,
    output reg clu_req,
    output reg clu_wr,
    output reg [2:0] clu_sel,
    output reg [31:0] clu_wdata,
    input wire [31:0] clu_rdata,
    output reg deferred_pending
);
    reg def_flag_reg;
    reg [1:0] layout_reg;
    reg [5:0] code_reg;
    reg format_indicator_reg;
    reg select_reg;
    reg [31:0] rd_next;
    reg [31:0] core_rd;
    wire win_acc;
    wire core_en;
    wire clu_en;
    wire [31:0] win_rdata;
    wire flag_allowed;
    localparam LAY_SHORT = 2'h0;
    localparam LAY_LONG = 2'h1;
    localparam LAY_EL2 = 2'h2;

    function is_window;
        input [2:0] s;
        begin
            is_window = (s >= `RAS_SEL_ADDR_LO);
        end
    endfunction

    assign win_acc = (reg_wr | reg_rd) & is_window(reg_sel);
    assign flag_allowed = (HAS_SYNC_SOURCES != 0) | (layout_reg != LAY_EL2);

    ras_win_mux u_mux (
        .sel(select_reg),
        .acc_en(win_acc),
        .core_rdata(core_rd),
        .clu_rdata(clu_rdata),
        .core_en(core_en),
        .clu_en(clu_en),
        .rdata(win_rdata)
    );

    // deferred status storage
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            def_flag_reg <= 1'b0;
            layout_reg <= LAY_SHORT;
            code_reg <= 6'h00;
            format_indicator_reg <= 1'b0;
            deferred_pending <= 1'b0;
        end
        else if (clk_en)
        begin
            if (reg_wr && reg_sel == `RAS_SEL_DEFERRED_ERROR_STATUS_CODE)
            begin
                if (wr_at_el2)
                begin
                    layout_reg <= LAY_EL2;
                    code_reg <= reg_wdata[5:0];
                    format_indicator_reg <= 1'b0;
                end
                else if (long_format_enable)
                begin
                    layout_reg <= LAY_LONG;
                    code_reg <= reg_wdata[5:0];
                    format_indicator_reg <= reg_wdata[`RAS_FMT_BIT];
                end
                else
                begin
                    layout_reg <= LAY_SHORT;
                    code_reg <= {1'b0, reg_wdata[`RAS_FS4_BIT], reg_wdata[3:0]};
                    format_indicator_reg <= reg_wdata[`RAS_FMT_BIT];
                end
            end
            // barrier set wins over a software write
            if (error_sync_barrier)
            begin
                def_flag_reg <= 1'b1;
                code_reg <= fault_status_code;
                format_indicator_reg <= long_format_enable;
                layout_reg <= long_format_enable ? LAY_LONG : LAY_SHORT;
            end
            else if (reg_wr && reg_sel == `RAS_SEL_DEFERRED_ERROR_STATUS_CODE)
                def_flag_reg <= reg_wdata[`RAS_DEF_BIT] &
                    ((HAS_SYNC_SOURCES != 0) | ~wr_at_el2);
            deferred_pending <= error_sync_barrier | def_flag_reg;
        end
    end

    // select register, cold reset only
    always @(posedge mclk or negedge cold_resetn)
    begin
        if (!cold_resetn)
            select_reg <= `RAS_SELECT_RESET;
        else if (clk_en && reg_wr && reg_sel == `RAS_SEL_SELECT)
            select_reg <= reg_wdata[0];
    end

    // core record storage
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            core_addr_reg <= 64'h0000000000000000;
            core_ctrl_reg <= 64'h0000000000000000;
        end
        else if (clk_en && reg_wr && core_en)
        begin
            case (reg_sel)
                `RAS_SEL_ADDR_LO: core_addr_reg[31:0] <= reg_wdata;
                `RAS_SEL_ADDR_HI: core_addr_reg[63:32] <= reg_wdata;
                `RAS_SEL_CTRL_LO: core_ctrl_reg[31:0] <= reg_wdata;
                `RAS_SEL_CTRL_HI: core_ctrl_reg[62:32] <= reg_wdata[30:0];
                default: core_ctrl_reg <= core_ctrl_reg;
            endcase
        end
    end

    always @*
    begin
        case (reg_sel)
            `RAS_SEL_ADDR_LO: core_rd = core_addr_reg[31:0];
            `RAS_SEL_ADDR_HI: core_rd = core_addr_reg[63:32];
            `RAS_SEL_CTRL_LO: core_rd = core_ctrl_reg[31:0];
            `RAS_SEL_CTRL_HI: core_rd = core_ctrl_reg[63:32] & `RAS_CTRL_HI_MASK;
            `RAS_SEL_FEAT_LO: core_rd = core_feature;
            default: core_rd = 32'h00000000;
        endcase
    end

    // read data assembly
    always @*
    begin
        rd_next = 32'h00000000;
        case (reg_sel)
            `RAS_SEL_DEFERRED_ERROR_STATUS_CODE:
            begin
                rd_next[`RAS_DEF_BIT] = def_flag_reg & flag_allowed;
                case (layout_reg)
                    LAY_EL2:
                    begin
                        rd_next[`RAS_AET2_HI:`RAS_AET2_LO] = `RAS_AET_UEU;
                        rd_next[5:0] = code_reg;
                    end
                    LAY_LONG:
                    begin
                        rd_next[`RAS_AET_HI:`RAS_AET_LO] = `RAS_AET_UEU;
                        rd_next[`RAS_FMT_BIT] = format_indicator_reg;
                        rd_next[5:0] = code_reg;
                    end
                    default:
                    begin
                        rd_next[`RAS_AET_HI:`RAS_AET_LO] = `RAS_AET_UEU;
                        rd_next[`RAS_FS4_BIT] = code_reg[4];
                        rd_next[`RAS_FMT_BIT] = format_indicator_reg;
                        rd_next[3:0] = code_reg[3:0];
                    end
                endcase
                // bit 12 never set in any layout
            end
            `RAS_SEL_COUNT: rd_next[15:0] = `RAS_RECORD_COUNT;
            `RAS_SEL_SELECT: rd_next[0] = select_reg;
            default: rd_next = win_rdata;
        endcase
    end

    // read port and cluster link
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= 32'h00000000;
            reg_rvalid <= 1'b0;
            clu_req <= 1'b0;
            clu_wr <= 1'b0;
            clu_sel <= 3'h0;
            clu_wdata <= 32'h00000000;
        end
        else if (clk_en)
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rd_next;
            clu_req <= clu_en & reg_wr;
            clu_wr <= clu_en & reg_wr;
            if (clu_en)
            begin
                clu_sel <= reg_sel;
                clu_wdata <= reg_wdata;
            end
        end
    end
endmodule

// ---- hw/ras_defs.vh ----
// register selectors, field positions and constant values for the error record system registers
`ifndef RAS_DEFS_VH
`define RAS_DEFS_VH
`define RAS_SEL_DEFERRED_ERROR_STATUS_CODE 3'h0
`define RAS_SEL_COUNT 3'h1
`define RAS_SEL_SELECT 3'h2
`define RAS_SEL_ADDR_LO 3'h3
`define RAS_SEL_ADDR_HI 3'h4
`define RAS_SEL_CTRL_LO 3'h5
`define RAS_SEL_CTRL_HI 3'h6
`define RAS_SEL_FEAT_LO 3'h7
`define RAS_DEF_BIT 31
`define RAS_AET_HI 15
`define RAS_AET_LO 14
`define RAS_AET2_HI 11
`define RAS_AET2_LO 10
`define RAS_AET_UEU 2'h1
`define RAS_FMT_BIT 9
`define RAS_FS4_BIT 10
`define RAS_RECORD_COUNT 16'h0002
`define RAS_CTRL_HI_MASK 32'h7FFFFFFF
`define RAS_SELECT_RESET 1'h0
`endif

// ---- hw/ras_win_mux.v ----
// routes a windowed record access to the core record or the shared cluster record
`timescale 1ns/1ps
module ras_win_mux (
    input wire sel,
    input wire acc_en,
    input wire [31:0] core_rdata,
    input wire [31:0] clu_rdata,
    output wire core_en,
    output wire clu_en,
    output wire [31:0] rdata
);
    assign core_en = acc_en & ~sel;
    assign clu_en = acc_en & sel;
    assign rdata = sel ? clu_rdata : core_rdata;
endmodule

// ---- tb/ras_sysregs_asserts.sv ----
// assertions on the error record system register ports
`timescale 1ns/1ps
module ras_sysregs_chk (
    input wire mclk,
    input wire resetn,
    input wire cold_resetn,
    input wire clk_en,
    input wire reg_wr,
    input wire reg_rd,
    input wire [2:0] reg_sel,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire reg_rvalid,
    input wire error_sync_barrier,
    input wire deferred_pending,
    input wire [63:0] core_addr_reg,
    input wire [63:0] core_ctrl_reg,
    input wire [31:0] core_feature,
    input wire clu_req,
    input wire clu_wr,
    input wire [2:0] clu_sel,
    input wire [31:0] clu_wdata
);
    reg sel_q;
    wire rd = clk_en && reg_rd;
    wire wx = clk_en && reg_wr && reg_sel >= 3'h3 && reg_sel <= 3'h6;
    wire wc = wx && !sel_q;
    always @(posedge mclk or negedge cold_resetn)
        if (!cold_resetn)
            sel_q <= 1'h0;
        else if (clk_en && reg_wr && reg_sel == 3'h2)
            sel_q <= reg_wdata[0];
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    chk_read_answer: assert property (rd |=> reg_rvalid)
        else $error("no read answer");
    chk_count_value: assert property (rd && reg_sel == 3'h1 |=> reg_rdata == 32'h00000002)
        else $error("bad count");
    chk_select_read: assert property (rd && reg_sel == 3'h2 |=> reg_rdata == {31'h0, $past(sel_q)})
        else $error("bad select");
    chk_barrier_flag: assert property (clk_en && error_sync_barrier |=> deferred_pending)
        else $error("flag not set");
    chk_core_local: assert property (wc |=> !clu_req)
        else $error("core write forwarded");
    chk_addr_low: assert property (wc && reg_sel == 3'h3 |=> core_addr_reg[31:0] == $past(reg_wdata))
        else $error("addr low");
    chk_addr_high: assert property (wc && reg_sel == 3'h4 |=> core_addr_reg[63:32] == $past(reg_wdata))
        else $error("addr high");
    chk_ctrl_high: assert property (wc && reg_sel == 3'h6 |=> core_ctrl_reg[62:32] == $past(reg_wdata[30:0]))
        else $error("ctrl high");
    chk_cluster_fwd: assert property (wx && sel_q |=> clu_req && clu_wr && clu_sel == $past(reg_sel) && clu_wdata == $past(reg_wdata))
        else $error("not forwarded");
    chk_feature_read: assert property (rd && reg_sel == 3'h7 && !sel_q |=> reg_rdata == $past(core_feature))
        else $error("feature");
    cover property (wx && sel_q);
    cover property (rd && reg_sel == 3'h0);
    cover property (clk_en && error_sync_barrier);
endmodule
bind ras_sysregs ras_sysregs_chk ras_sysregs_chk_i (.mclk, .resetn, .cold_resetn, .clk_en, .reg_wr,
    .reg_rd, .reg_sel, .reg_wdata, .reg_rdata, .reg_rvalid, .error_sync_barrier, .deferred_pending,
    .core_addr_reg, .core_ctrl_reg, .core_feature, .clu_req, .clu_wr, .clu_sel, .clu_wdata);

// ---- tb/ras_clu_model.sv ----
// behavioural error record of the shared cluster unit
`timescale 1ns/1ps
module ras_clu_model (
    input wire mclk,
    input wire clu_req,
    input wire clu_wr,
    input wire [2:0] clu_sel,
    input wire [31:0] clu_wdata,
    output wire [31:0] clu_rdata
);
    reg [31:0] mem [0:7];
    integer k;
    initial
    begin
        for (k = 0; k < 8; k = k + 1)
            mem[k] = 32'hA5A50000 + k;
    end
    always @(posedge mclk)
        if (clu_req && clu_wr)
            mem[clu_sel] <= clu_wdata;
    assign clu_rdata = mem[clu_sel];
endmodule

// ---- tb/tb.sv ----
// testbench for the error record system registers
`timescale 1ns/1ps
module tb;
    reg mclk = 0, resetn = 0, cold_resetn = 0, reg_wr = 0, reg_rd = 0, clk_en = 1;
    reg wr_at_el2 = 0, long_format_enable = 0, error_sync_barrier = 0;
    reg [2:0] reg_sel = 3'h0;
    reg [5:0] fault_status_code = 6'h0;
    reg [31:0] reg_wdata = 32'h0, core_feature = 32'h13572468;
    reg [31:0] wv [0:3];
    wire [31:0] reg_rdata, clu_wdata, clu_rdata;
    wire [63:0] core_addr_reg, core_ctrl_reg;
    wire [2:0] clu_sel;
    wire reg_rvalid, clu_req, clu_wr, deferred_pending;
    integer error_cnt = 0, total_checks = 0, cyc = 0, i;
    always #12.5 mclk = ~mclk;
    ras_sysregs ras_sysregs_i (.mclk, .resetn, .cold_resetn, .clk_en, .reg_wr, .reg_rd,
        .reg_sel, .reg_wdata, .wr_at_el2, .long_format_enable, .reg_rdata, .reg_rvalid,
        .error_sync_barrier, .fault_status_code, .core_addr_reg, .core_ctrl_reg, .core_feature,
        .clu_req, .clu_wr, .clu_sel, .clu_wdata, .clu_rdata, .deferred_pending);
    ras_clu_model ras_clu_model_i (.mclk, .clu_req, .clu_wr, .clu_sel, .clu_wdata, .clu_rdata);
    task chk(input [31:0] got, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [2:0] s, input [31:0] d);
    begin
        @(negedge mclk);
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge mclk);
        reg_wr = 0;
    end
    endtask
    task rd(input [2:0] s, input [31:0] e);
    begin
        @(negedge mclk);
        reg_sel = s;
        reg_rd = 1;
        @(negedge mclk);
        reg_rd = 0;
        chk({31'h0, reg_rvalid}, 32'h1);
        chk(reg_rdata, e);
    end
    endtask
    task defer(input l, input [5:0] c);
    begin
        @(negedge mclk);
        long_format_enable = l;
        fault_status_code = c;
        error_sync_barrier = 1;
        @(negedge mclk);
        error_sync_barrier = 0;
    end
    endtask
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    always @(posedge mclk)
    begin
        cyc = cyc + 1;
        if (cyc == 2000)
        begin
            error_cnt = error_cnt + 1;
            print_verdict;
        end
    end
    initial
    begin
        wv[0] = 32'h89ABCDEF;
        wv[1] = 32'h01234567;
        wv[2] = 32'hFEDC0123;
        wv[3] = 32'hFFFFFFFF;
        repeat (10) @(negedge mclk);
        resetn = 1;
        cold_resetn = 1;
        rd(3'h1, 32'h00000002);
        wr(3'h1, 32'hFFFFFFFF);
        rd(3'h1, 32'h00000002);
        wr(3'h2, 32'hFFFFFFFE);
        rd(3'h2, 32'h0);
        $display("test count and select done");
        for (i = 3; i < 7; i++)
            wr(i[2:0], wv[i - 3]);
        for (i = 3; i < 6; i++)
            rd(i[2:0], wv[i - 3]);
        rd(3'h6, 32'h7FFFFFFF);
        rd(3'h7, 32'h13572468);
        $display("test core record done");
        wr(3'h2, 32'hFFFFFFFF);
        wr(3'h3, 32'h600DF00D);
        rd(3'h3, 32'h600DF00D);
        wr(3'h2, 32'h0);
        rd(3'h3, 32'h89ABCDEF);
        wr(3'h2, 32'h1);
        @(negedge mclk);
        resetn = 0;
        @(negedge mclk);
        resetn = 1;
        rd(3'h2, 32'h1);
        clk_en = 0;
        wr(3'h2, 32'h0);
        clk_en = 1;
        rd(3'h2, 32'h1);
        $display("test cluster record done");
        defer(0, 6'h15);
        rd(3'h0, 32'h80004405);
        chk({31'h0, deferred_pending}, 32'h1);
        defer(1, 6'h2A);
        rd(3'h0, 32'h8000422A);
        wr(3'h0, 32'h00004200);
        rd(3'h0, 32'h00004200);
        wr_at_el2 = 1;
        wr(3'h0, 32'hFFFFF7FF);
        rd(3'h0, 32'h8000043F);
        $display("test deferred status done");
        print_verdict;
    end
endmodule
